// ==== verilog/clcd_map.svh ====
// constants for the character display command decoder: timing, sizes, resets
// assumes a 20 MHz core clock and a host that keeps its own bus timing
`ifndef CLCD_MAP_SVH
`define CLCD_MAP_SVH

`define CLCD_CLK_MHZ 20
`define CLCD_OSC_KHZ 270
`define CLCD_T_LONG_NS 1530000
`define CLCD_T_CMD_NS 39000
`define CLCD_T_DATA_NS 43000
`define CLCD_CYC(ns) ((((ns) * `CLCD_CLK_MHZ) + 999) / 1000)

`define CLCD_DD_LAST 7'h7F
`define CLCD_CG_BASE 8'h80
`define CLCD_MEM_DEPTH 192
`define CLCD_FIFO_DEPTH 16
`define CLCD_CLEAR_FILL 8'h00

`define CLCD_RST_WIDTH8 1'b1
`define CLCD_RST_INC 1'b1
`define CLCD_RST_OFF 1'b0

`endif

// ==== verilog/clcd_pkg.sv ====
// types shared by the character display command decoder, its checker and its bench
// assumes clcd_map.svh supplies the numeric constants
`default_nettype none
package clcd_pkg;

  typedef struct packed {
    logic select;
    logic readSel;
    logic [7:0] data;
  } clcd_cmd_s;

  typedef struct packed {
    logic select;
    logic readSel;
    logic enable;
    logic [7:0] data;
  } clcd_pins_s;

  typedef enum logic {ST_IDLE, ST_EXEC} clcd_exec_e;

  typedef struct packed {
    logic displayOn;
    logic cursorOn;
    logic blinkOn;
    logic busWidthSelect;
    logic twoLines;
    logic tallFont;
    logic entryIncrement;
    logic wholeViewScrollEnable;
  } clcd_mode_s;

  typedef struct packed {
    clcd_pins_s sync1;
    clcd_pins_s sync2;
    logic enPrev;
    clcd_exec_e state;
    logic [15:0] count;
    logic clearing;
    logic [6:0] clearIdx;
    logic [6:0] ramPointer;
    logic glyphSel;
    logic [6:0] viewShift;
    clcd_mode_s mode;
    logic nibbleLow;
    logic [3:0] hiNibble;
    logic [7:0] dataOut;
    logic dataOe;
  } clcd_state_s;

endpackage
`default_nettype wire

// ==== verilog/clcd_fifo.sv ====
// small synchronous queue with valid/ready on both sides
// assumes one clock and an active-low asynchronous reset
`default_nettype none
module clcd_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // filling side
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  // draining side
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } clcd_fifo_s;

  clcd_fifo_s q;
  clcd_fifo_s d;
  logic [WIDTH-1:0] store [DEPTH];
  logic push;
  logic pop;

  assign inReady = (q.count != (AW+1)'(DEPTH));
  assign outValid = (q.count != '0);
  assign outData = store[q.rd];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_comb begin
    d = q;
    if (push) begin
      d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : AW'(q.wr + 1'b1);
    end
    if (pop) begin
      d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : AW'(q.rd + 1'b1);
    end
    if (push && !pop) begin
      d.count = (AW+1)'(q.count + 1'b1);
    end else if (pop && !push) begin
      d.count = (AW+1)'(q.count - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      store[q.wr] <= inData;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/clcd_command_decoder.sv ====
// character display command decoder: parallel host port, queue, executor,
// display and glyph memories
// assumes the host pins are asynchronous and held steady around each strobe
`include "clcd_map.svh"
`default_nettype none

module clcd_command_decoder
  import clcd_pkg::*;
#(
  parameter int OSC_KHZ = `CLCD_OSC_KHZ,
  parameter int LONG_CYCLES = `CLCD_CYC(`CLCD_T_LONG_NS) * `CLCD_OSC_KHZ
    / OSC_KHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // host bus pins
  input wire logic instrDataSelect,
  input wire logic readNotWrite,
  input wire logic enable,
  input wire logic [7:0] busDataIn,
  output logic [7:0] busDataOut,
  output logic busDataOe,
  // status and configuration
  output logic internalOpFlag,
  output logic cmdAccept,
  output logic [6:0] ramPointer,
  output logic glyphSelect,
  output logic [6:0] viewShift,
  output clcd_pkg::clcd_mode_s mode
);
  import clcd_pkg::*;

  localparam int CMD_CYCLES = `CLCD_CYC(`CLCD_T_CMD_NS) * `CLCD_OSC_KHZ
    / OSC_KHZ;
  localparam int DATA_CYCLES = `CLCD_CYC(`CLCD_T_DATA_NS) * `CLCD_OSC_KHZ
    / OSC_KHZ;
  localparam logic [15:0] LONG_LOAD = 16'(LONG_CYCLES - 1);
  localparam logic [15:0] CMD_LOAD = 16'(CMD_CYCLES - 1);
  localparam logic [15:0] DATA_LOAD = 16'(DATA_CYCLES - 1);

  clcd_state_s q;
  clcd_state_s d;
  clcd_cmd_s pushCmd;
  clcd_cmd_s popCmd;
  logic [$bits(clcd_cmd_s)-1:0] popRaw;
  logic pushValid;
  logic popValid;
  logic popReady;
  logic enRise;
  logic enFall;
  logic nibbleMode;
  logic lastPart;
  logic [7:0] rdByte;
  logic [7:0] memQ;
  logic memWe;
  logic [7:0] memWaddr;
  logic [7:0] memWdata;
  logic [7:0] charMem [`CLCD_MEM_DEPTH];

  // glyph memory sits above the display memory in one array
  function automatic logic [7:0] memAddr(input logic glyph,
                                         input logic [6:0] ptr);
    memAddr = glyph ? 8'(`CLCD_CG_BASE + {2'h0, ptr[5:0]}) : {1'b0, ptr};
  endfunction

  // pointer step; glyph addresses wrap within six bits
  function automatic logic [6:0] stepPtr(input logic [6:0] ptr,
                                         input logic up,
                                         input logic glyph);
    logic [6:0] nxt;
    nxt = up ? 7'(ptr + 7'h01) : 7'(ptr - 7'h01);
    stepPtr = glyph ? {1'b0, nxt[5:0]} : nxt;
  endfunction

  clcd_fifo #(
    .WIDTH($bits(clcd_cmd_s)),
    .DEPTH(`CLCD_FIFO_DEPTH)
  ) cmdQueue (
    .clk(clk),
    .resetn(resetn),
    .inData(pushCmd),
    .inValid(pushValid),
    .inReady(cmdAccept),
    .outData(popRaw),
    .outValid(popValid),
    .outReady(popReady)
  );

  assign popCmd = clcd_cmd_s'(popRaw);
  assign enRise = q.sync2.enable & ~q.enPrev;
  assign enFall = ~q.sync2.enable & q.enPrev;
  assign nibbleMode = ~q.mode.busWidthSelect;
  assign lastPart = ~nibbleMode | q.nibbleLow;
  assign popReady = (q.state == ST_IDLE);
  assign internalOpFlag = (q.state == ST_EXEC) | popValid;
  // busy flag and pointer straight from state, no queueing
  assign rdByte = q.sync2.select ? memQ
                                 : {internalOpFlag, q.ramPointer};

  always_comb begin
    d = q;
    pushValid = 1'b0;
    pushCmd = '0;
    memWe = 1'b0;
    memWaddr = 8'h00;
    memWdata = 8'h00;

    // host pins pass two stages before anything looks at them
    d.sync1 = '{select: instrDataSelect, readSel: readNotWrite,
                enable: enable, data: busDataIn};
    d.sync2 = q.sync1;
    d.enPrev = q.sync2.enable;

    // reads: present the byte, or its nibble, while the strobe is high
    if (enRise && q.sync2.readSel) begin
      d.dataOe = 1'b1;
      if (!nibbleMode) begin
        d.dataOut = rdByte;
      end else if (q.nibbleLow) begin
        d.dataOut = {rdByte[3:0], 4'h0};
      end else begin
        d.dataOut = {rdByte[7:4], 4'h0};
      end
    end
    if (!q.sync2.enable) begin
      d.dataOe = 1'b0;
    end

    // strobe end: pair nibbles, then queue all but busy reads
    if (enFall) begin
      if (nibbleMode) begin
        d.nibbleLow = ~q.nibbleLow;
      end
      if (!lastPart) begin
        d.hiNibble = q.sync2.data[7:4];
      end
      pushValid = lastPart & ~(q.sync2.readSel & ~q.sync2.select);
      pushCmd.select = q.sync2.select;
      pushCmd.readSel = q.sync2.readSel;
      pushCmd.data = nibbleMode ? {q.hiNibble, q.sync2.data[7:4]}
                                : q.sync2.data;
    end

    case (q.state)
      ST_IDLE: begin
        if (popValid) begin
          d.state = ST_EXEC;
          d.count = CMD_LOAD;
          if (popCmd.select) begin
            d.count = DATA_LOAD;
            d.ramPointer = stepPtr(q.ramPointer, q.mode.entryIncrement,
                                   q.glyphSel);
            if (!popCmd.readSel) begin
              memWe = 1'b1;
              memWaddr = memAddr(q.glyphSel, q.ramPointer);
              memWdata = popCmd.data;
              if (q.mode.wholeViewScrollEnable && !q.glyphSel) begin
                d.viewShift = q.mode.entryIncrement ? 7'(q.viewShift + 7'h01)
                                                    : 7'(q.viewShift - 7'h01);
              end
            end
          end else begin
            casez (popCmd.data)
              8'b1???????: begin
                d.ramPointer = popCmd.data[6:0];
                d.glyphSel = 1'b0;
              end
              8'b01??????: begin
                d.ramPointer = {1'b0, popCmd.data[5:0]};
                d.glyphSel = 1'b1;
              end
              8'b001?????: begin
                d.mode.busWidthSelect = popCmd.data[4];
                d.mode.twoLines = popCmd.data[3];
                d.mode.tallFont = popCmd.data[2];
                d.nibbleLow = 1'b0;
              end
              8'b0001????: begin
                if (popCmd.data[3]) begin
                  d.viewShift = popCmd.data[2] ? 7'(q.viewShift - 7'h01)
                                               : 7'(q.viewShift + 7'h01);
                end else begin
                  d.ramPointer = stepPtr(q.ramPointer, popCmd.data[2],
                                         q.glyphSel);
                end
              end
              8'b00001???: begin
                d.mode.displayOn = popCmd.data[2];
                d.mode.cursorOn = popCmd.data[1];
                d.mode.blinkOn = popCmd.data[0];
              end
              8'b000001??: begin
                d.mode.entryIncrement = popCmd.data[1];
                d.mode.wholeViewScrollEnable = popCmd.data[0];
              end
              8'b0000001?: begin
                d.ramPointer = 7'h00;
                d.glyphSel = 1'b0;
                d.viewShift = 7'h00;
                d.count = LONG_LOAD;
              end
              8'b00000001: begin
                d.ramPointer = 7'h00;
                d.glyphSel = 1'b0;
                d.clearing = 1'b1;
                d.clearIdx = 7'h00;
                d.count = LONG_LOAD;
              end
              default: begin
                d.count = CMD_LOAD;
              end
            endcase
          end
        end
      end
      ST_EXEC: begin
        if (q.clearing) begin
          memWe = 1'b1;
          memWaddr = {1'b0, q.clearIdx};
          memWdata = `CLCD_CLEAR_FILL;
          d.clearIdx = 7'(q.clearIdx + 7'h01);
          if (q.clearIdx == `CLCD_DD_LAST) begin
            d.clearing = 1'b0;
          end
        end
        if (q.count != 16'h0000) begin
          d.count = 16'(q.count - 16'h0001);
        end else if (!q.clearing) begin
          d.state = ST_IDLE;
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.state <= ST_IDLE;
      q.mode.busWidthSelect <= `CLCD_RST_WIDTH8;
      q.mode.entryIncrement <= `CLCD_RST_INC;
      q.mode.displayOn <= `CLCD_RST_OFF;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (memWe) begin
      charMem[memWaddr] <= memWdata;
    end
    memQ <= charMem[memAddr(q.glyphSel, q.ramPointer)];
  end

  assign busDataOut = q.dataOut;
  assign busDataOe = q.dataOe;
  assign ramPointer = q.ramPointer;
  assign glyphSelect = q.glyphSel;
  assign viewShift = q.viewShift;
  assign mode = q.mode;

endmodule
`default_nettype wire

// ==== testbench/clcd_command_decoder_chk.sv ====
// port checker for the character display command decoder
// assumes it is bound into clcd_command_decoder
`default_nettype none
module clcd_command_decoder_chk
  import clcd_pkg::*;
#(
  parameter int LONG_CYCLES = 200
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // host bus
  input wire logic instrDataSelect,
  input wire logic readNotWrite,
  input wire logic enable,
  input wire logic [7:0] busDataOut,
  input wire logic busDataOe,
  // status
  input wire logic internalOpFlag,
  input wire logic cmdAccept,
  input wire logic [6:0] ramPointer,
  input wire clcd_pkg::clcd_mode_s mode
);
  // shortest legal busy stretch: long operations or a 39 us instruction
  localparam int MIN_RUN = (LONG_CYCLES < 780) ? LONG_CYCLES : 780;
  logic [15:0] runLen_q;
  logic [15:0] runLen_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // length of the current busy stretch
  always_comb begin
    runLen_d = internalOpFlag ? runLen_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      runLen_q <= 16'h0000;
    end else begin
      runLen_q <= runLen_d;
    end
  end
  a_oe_read: assert property (busDataOe |-> readNotWrite)
    else $error("bus driven outside a read");
  a_oe_strobe: assert property ($rose(busDataOe) |-> $past(enable, 2))
    else $error("bus driven without strobe");
  // whole status byte only in 8-bit bus mode; 4-bit mode returns nibbles
  a_status_read: assert property ($rose(busDataOe) && !instrDataSelect
    && mode.busWidthSelect
    |-> busDataOut == {$past(internalOpFlag), $past(ramPointer)})
    else $error("status byte wrong");
  a_status_quiet: assert property ($fell(busDataOe) && !instrDataSelect
    && !internalOpFlag |-> !internalOpFlag [*4])
    else $error("status read made busy");
  a_busy_start: assert property ($rose(internalOpFlag)
    |-> !$past(enable, 3))
    else $error("busy without strobe end");
  a_busy_len: assert property ($fell(internalOpFlag)
    |-> runLen_q >= MIN_RUN)
    else $error("busy stretch too short");
  a_ptr_exec: assert property ($changed(ramPointer) |-> internalOpFlag)
    else $error("pointer moved while idle");
  a_mode_exec: assert property ($changed(mode) |-> internalOpFlag)
    else $error("mode moved while idle");
  c_full: cover property ($fell(cmdAccept));
  c_status: cover property ($rose(busDataOe) && !instrDataSelect);
  c_long: cover property ($fell(internalOpFlag) && runLen_q > 16'h0320);
endmodule

bind clcd_command_decoder clcd_command_decoder_chk #(
  .LONG_CYCLES(LONG_CYCLES)
) clcd_command_decoder_chk_inst (.clk, .resetn, .instrDataSelect,
  .readNotWrite, .enable, .busDataOut, .busDataOe, .internalOpFlag,
  .cmdAccept, .ramPointer, .mode);
`default_nettype wire

// ==== testbench/clcd_host_model.sv ====
// host processor model driving strobed accesses on the parallel port
// assumes the decoder samples its pins on rising clk edges
`default_nettype none
module clcd_host_model (
  // clock
  input wire logic clk,
  // host pins
  output logic instrDataSelect,
  output logic readNotWrite,
  output logic enable,
  output logic [7:0] busDataIn,
  // device side
  input wire logic [7:0] busDataOut,
  input wire logic busDataOe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] hostData = 8'h00;
  // the wire carries the device byte while it drives
  assign busDataIn = busDataOe ? busDataOut : hostData;
  initial begin
    instrDataSelect = 1'b0;
    readNotWrite = 1'b0;
    enable = 1'b0;
  end
  task automatic access(input logic rs, input logic rw,
    input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    instrDataSelect = rs;
    readNotWrite = rw;
    hostData = d;
    @(negedge clk);
    enable = 1'b1;
    repeat (8) @(negedge clk);
    q = busDataOut;
    enable = 1'b0;
    repeat (6) @(negedge clk);
    // released lines show the inverse of the last byte
    hostData = ~d;
  endtask
endmodule
`default_nettype wire

// ==== testbench/clcd_command_decoder_tb.sv ====
// self-checking bench for the character display command decoder
// assumes the host model and checker are compiled before it
`default_nettype none
module clcd_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import clcd_pkg::*;
  localparam int LONG = 200;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic instrDataSelect, readNotWrite, enable, busDataOe;
  logic internalOpFlag, cmdAccept, glyphSelect, sawFull;
  logic [7:0] busDataIn, busDataOut, q;
  logic [6:0] ramPointer, viewShift;
  clcd_mode_s mode;
  int error_cnt = 0;
  int tests_run = 0;
  int busyCnt = 0;
  int lastRun = 0;
  // instruction, mode, glyph and pointer, view shift
  logic [31:0] rows [17] = '{32'h0FF20000, 32'h08120000, 32'h3C1E0000,
    32'h381A0000, 32'h05190000, 32'h061A0000, 32'h851A0500, 32'h141A0600,
    32'h101A0500, 32'h181A0501, 32'h1C1A0500, 32'h181A0501, 32'h021A0000,
    32'h7F1ABF00, 32'hFF1A7F00, 32'h131A7E00, 32'h011A0000};
  always #25 clk = ~clk;
  // busy length sampled on the quiet edge, away from the design's updates
  always @(negedge clk) begin
    if (internalOpFlag === 1'b1) begin
      busyCnt <= busyCnt + 1;
    end else begin
      if (busyCnt > 0) lastRun <= busyCnt;
      busyCnt <= 0;
    end
  end
  clcd_command_decoder #(.LONG_CYCLES(LONG)) clcd_command_decoder_inst (
    .clk, .resetn, .instrDataSelect, .readNotWrite, .enable, .busDataIn,
    .busDataOut, .busDataOe, .internalOpFlag, .cmdAccept, .ramPointer,
    .glyphSelect, .viewShift, .mode);
  clcd_host_model clcd_host_model_inst (.clk, .instrDataSelect,
    .readNotWrite, .enable, .busDataIn, .busDataOut, .busDataOe);
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkLen(input string n, input int e, input int g);
    tests_run++;
    if (g < e || g > e + 3) begin
      error_cnt++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic waitIdle;
    int i;
    for (i = 0; i < 20000 && internalOpFlag !== 1'b0; i++) @(negedge clk);
    chk("idle", 8'h00, {7'h00, internalOpFlag});
    // let the busy-length monitor store its count before anyone reads it
    @(posedge clk);
  endtask
  task automatic op(input logic rs, input logic rw, input logic [7:0] d);
    clcd_host_model_inst.access(rs, rw, d, q);
    waitIdle();
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    $display("[FAIL] run time expected done seen hang");
    close_out();
  end
  initial begin
    int i;
    logic [7:0] d;
    repeat (4) @(negedge clk);
    chk("reset status", 8'h01, {5'h00, busDataOe, internalOpFlag, cmdAccept});
    chk("reset mode", 8'h12, mode);
    chk("reset pointer", 8'h00, {glyphSelect, ramPointer});
    $display("reset test done");
    resetn = 1'b1;
    for (i = 0; i < 17; i++) begin
      d = rows[i][31:24];
      op(1'b0, 1'b0, d);
      chk("mode", rows[i][23:16], mode);
      chk("pointer", rows[i][15:8], {glyphSelect, ramPointer});
      chk("view shift", rows[i][7:0], {1'b0, viewShift});
      chkLen("busy", (d < 8'h03) ? LONG : 780, lastRun);
    end
    $display("instruction table done");
    for (i = 0; i < 4; i++) op(1'b1, 1'b0, 8'hA1 + 8'h11 * i[7:0]);
    chkLen("write busy", 860, lastRun);
    chk("pointer", 8'h04, {glyphSelect, ramPointer});
    op(1'b0, 1'b0, 8'h80);
    for (i = 0; i < 4; i++) begin
      op(1'b1, 1'b1, 8'h00);
      chk("read", 8'hA1 + 8'h11 * i[7:0], q);
    end
    chkLen("read busy", 860, lastRun);
    op(1'b0, 1'b0, 8'h40);
    op(1'b1, 1'b0, 8'h5A);
    op(1'b0, 1'b0, 8'h40);
    op(1'b1, 1'b1, 8'h00);
    chk("glyph read", 8'h5A, q);
    op(1'b0, 1'b0, 8'h80);
    op(1'b1, 1'b1, 8'h00);
    op(1'b0, 1'b0, 8'h02);
    op(1'b1, 1'b1, 8'h00);
    chk("home keeps data", 8'hA1, q);
    op(1'b0, 1'b0, 8'h01);
    op(1'b1, 1'b1, 8'h00);
    chk("clear fill", 8'h00, q);
    $display("memory tests done");
    clcd_host_model_inst.access(1'b1, 1'b0, 8'h77, q);
    clcd_host_model_inst.access(1'b0, 1'b1, 8'h00, q);
    chk("status busy", 8'h82, q);
    waitIdle();
    op(1'b0, 1'b1, 8'h00);
    chk("status idle", 8'h02, q);
    op(1'b0, 1'b0, 8'h07);
    op(1'b1, 1'b0, 8'h22);
    chk("scroll on write", 8'h01, {1'b0, viewShift});
    op(1'b0, 1'b0, 8'h04);
    op(1'b1, 1'b0, 8'h11);
    chk("step down", 8'h02, {glyphSelect, ramPointer});
    sawFull = 1'b0;
    for (i = 0; i < 18; i++) begin
      clcd_host_model_inst.access(1'b0, 1'b0, 8'h08, q);
      if (cmdAccept === 1'b0) sawFull = 1'b1;
    end
    chk("queue full", 8'h01, {7'h00, sawFull});
    waitIdle();
    chk("queue drained", 8'h01, {7'h00, cmdAccept});
    $display("queue test done");
    op(1'b0, 1'b0, 8'h28);
    chk("four bit mode", 8'h08, mode);
    op(1'b0, 1'b0, 8'h30);
    op(1'b0, 1'b0, 8'hC0);
    chk("nibble pair", 8'h1C, mode);
    $display("bus width test done");
    close_out();
  end
endmodule
`default_nettype wire
